// ### tcc_defs.svh
// Register offsets, field positions, edge codes, reset values and counter limits of the timer
//Contract
//RULE1 - Run mode 01 counts up each tick
//RULE2 - FFFF wraps to 0000, sets wrap flag
//RULE3 - Software clears wrap flag by writing 0
//RULE4 - Compare A match raises event A
//RULE5 - Compare B match raises event B
//RULE6 - Matches do not clear counter normally
//RULE7 - A captures on selectable trigger edge
//RULE8 - B captures on trigger A edges only
//RULE9 - Trigger B detection disables toggle output
//RULE10 - Compare/compare: toggle and event per match
//RULE11 - B capture: latch counter, raise event B
//RULE12 - Capture/capture: toggle only on edge bit
//RULE13 - Capture/capture: A edge loads B, B loads A
//RULE14 - Only trigger B enabled: B never loads
//RULE15 - Invert select 10 B only, 11 both
//RULE16 - Mode 11: restart on A match, square wave
//RULE17 - Period A+1, high width B+1 ticks
//RULE18 - Mode 10: trigger A edge clears counter
//RULE19 - Counter read does not disturb counting
//RULE20 - Mode 10: capture then clear to 0000
//RULE21 - Reverse phase capture of A, no event
//RULE22 - Mode 00 stops counter at zero
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// Byte offsets on the register bus
`define TCC_OFS_MODE     5'h00
`define TCC_OFS_CAPCTL   5'h04
`define TCC_OFS_OUTCTL   5'h08
`define TCC_OFS_PRESCL   5'h0C
`define TCC_OFS_COUNT    5'h10
`define TCC_OFS_MATCH_A  5'h14
`define TCC_OFS_MATCH_B  5'h18

// Mode control fields
`define TCC_MODE_HI      3
`define TCC_MODE_LO      2
`define TCC_EDGE_OUT_BIT 1
`define TCC_WRAP_BIT     0

// Capture control fields
`define TCC_A_CAP_BIT    0
`define TCC_REV_CAP_BIT  1
`define TCC_B_CAP_BIT    2

// Output control fields
`define TCC_OE_BIT       0
`define TCC_INV_A_BIT    1
`define TCC_LVL_CLR_BIT  2
`define TCC_LVL_SET_BIT  3
`define TCC_INV_B_BIT    4

// Prescaler fields
`define TCC_DIV_HI       1
`define TCC_DIV_LO       0
`define TCC_ESA_HI       5
`define TCC_ESA_LO       4
`define TCC_ESB_HI       7
`define TCC_ESB_LO       6

// Edge select codes
`define TCC_ES_FALL      2'h0
`define TCC_ES_RISE      2'h1
`define TCC_ES_NONE      2'h2
`define TCC_ES_BOTH      2'h3

// Counter limits and reset values
`define TCC_CNT_MAX      16'hFFFF
`define TCC_CNT_ZERO     16'h0000
`define TCC_CTL_RST      8'h00
`define TCC_PRS_RST      8'hA0
`define TCC_RD_ZERO      32'h0000_0000

`endif

// ### tcc_pkg.sv
// Types shared by the capture/compare timer
package tcc_pkg;

	// Counter run modes
	typedef enum logic [1:0] {
		TCC_RUN_STOP    = 2'b00,
		TCC_RUN_FREE    = 2'b01,
		TCC_RUN_EDGE    = 2'b10,
		TCC_RUN_RESTART = 2'b11
	} tcc_run_e;

	// Counter word
	typedef logic [15:0] tcc_count_t;

endpackage

// ### tcc_timer.sv
// Capture/compare timer with pulse output and Avalon-MM register slave
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "tcc_defs.svh"

module tcc_timer #(
	parameter int CNT_W = 16
) (
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              trigger_in_a,
	input  wire logic              trigger_in_b,
	output logic                   toggle_output,
	output logic                   event_a_irq,
	output logic                   event_b_irq
);

	// Counter with two capture/compare registers and pulse output
	// Registers reached over a single-clock bus slave
	// Software registers
	logic [7:0]             timer_mode_control;       // Run mode, edge-out, wrap
	logic [7:0]             capture_compare_control;  // Capture selects
	logic [7:0]             timer_output_control;     // Output enables
	logic [7:0]             prescaler_mode_control;   // Divider and edges
	tcc_pkg::tcc_count_t    up_counter_value;         // Running count
	tcc_pkg::tcc_count_t    match_capture_a;          // Register A
	tcc_pkg::tcc_count_t    match_capture_b;          // Register B
	logic                   out_level;                // Pulse level
	logic [2:0]             div_cnt;                  // Prescale counter
	logic                   tick;                     // Count clock enable
	logic [2:0]             div_mask;                 // Divider mask
	tcc_pkg::tcc_run_e      run_mode;                 // Decoded mode

	// Synchronisers and edge history
	logic [1:0]             sync_a;                   // Trigger A stages
	logic [1:0]             sync_b;                   // Trigger B stages
	logic                   prev_a;                   // Trigger A history
	logic                   prev_b;                   // Trigger B history

	// Derived combinationally from registered state
	// Decoded events
	logic                   rise_a;
	logic                   fall_a;
	logic                   rise_b;
	logic                   fall_b;
	logic                   valid_a;                  // Valid edge on A
	logic                   valid_b;                  // Valid edge on B
	logic                   opposite_a;               // Reverse edge on A
	logic                   a_is_cap;                 // A in capture use
	logic                   b_is_cap;                 // B in capture use
	logic                   rev_cap;                  // Reverse phase select
	logic                   cap_a_evt;                // Load A from counter
	logic                   cap_b_evt;                // Load B from counter
	logic                   match_a_evt;              // A compare match
	logic                   match_b_evt;              // B compare match
	logic                   edge_clear;               // Mode 10 clear
	logic                   wrap_evt;                 // Counter wrapped
	logic                   b_detect_used;            // Trigger B edge on

	// Bus strobes
	logic                   bus_wr;                   // Accepted write
	logic                   next_waitrequest;

	// Field decode of the control registers
	// Every two-bit code is a legal mode, so the cast is safe
	assign run_mode = tcc_pkg::tcc_run_e'(timer_mode_control[`TCC_MODE_HI:`TCC_MODE_LO]);
	assign a_is_cap = capture_compare_control[`TCC_A_CAP_BIT];
	assign b_is_cap = capture_compare_control[`TCC_B_CAP_BIT];
	assign rev_cap  = capture_compare_control[`TCC_REV_CAP_BIT];

	// Request accepted once wait has dropped
	// Acts only at the edge where the master sees wait low,
	// so a held request is never applied twice
	assign bus_wr = avs_write && !avs_waitrequest;

	// One wait cycle per access, then released
	// Back-to-back requests meet wait high again first,
	// giving two clocks per access
	assign next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);

	// Bus handshake flop
	// High at rest, so no request is answered early
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= next_waitrequest;
		end
	end

	// Read data captured during the wait cycle
	// Registered, so the data stands while wait is low
	// Unmapped offsets read as zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= `TCC_RD_ZERO;
		end else if (avs_read && avs_waitrequest) begin
			unique case (avs_address)
				`TCC_OFS_MODE:    avs_readdata <= {24'h000000, timer_mode_control};
				`TCC_OFS_CAPCTL:  avs_readdata <= {24'h000000, capture_compare_control};
				`TCC_OFS_OUTCTL:  avs_readdata <= {24'h000000, timer_output_control};
				`TCC_OFS_PRESCL:  avs_readdata <= {24'h000000, prescaler_mode_control};
				`TCC_OFS_COUNT:   avs_readdata <= {16'h0000, up_counter_value}; // RULE19
				`TCC_OFS_MATCH_A: avs_readdata <= {16'h0000, match_capture_a};
				`TCC_OFS_MATCH_B: avs_readdata <= {16'h0000, match_capture_b};
				default:          avs_readdata <= `TCC_RD_ZERO; // Unmapped reads zero
			endcase
		end
	end

	// Two-stage synchronisers for the trigger pins
	// Pins are asynchronous; only the second stage feeds logic
	// History flops reset low to match the idle pin level
	// Pin edges reach the logic two clocks after the pin moves
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else begin
			sync_a <= {sync_a[0], trigger_in_a};
			sync_b <= {sync_b[0], trigger_in_b};
			prev_a <= sync_a[1];
			prev_b <= sync_b[1];
		end
	end

	// Edge strobes last one clock each
	// Pin pulses shorter than two clocks may merge
	assign rise_a = sync_a[1] && !prev_a;
	assign fall_a = !sync_a[1] && prev_a;
	assign rise_b = sync_b[1] && !prev_b;
	assign fall_b = !sync_b[1] && prev_b;

	// Valid and reverse-phase edge decode
	// Opposite edge of A feeds reverse-phase capture only
	// With both edges selected the opposite edge is any edge
	always_comb begin
		unique case (prescaler_mode_control[`TCC_ESA_HI:`TCC_ESA_LO])
			`TCC_ES_FALL: begin
				valid_a    = fall_a;
				opposite_a = rise_a;
			end
			`TCC_ES_RISE: begin
				valid_a    = rise_a;
				opposite_a = fall_a;
			end
			`TCC_ES_BOTH: begin
				valid_a    = rise_a || fall_a;
				opposite_a = rise_a || fall_a;
			end
			default: begin
				valid_a    = 1'b0;
				opposite_a = 1'b0;
			end
		endcase
		unique case (prescaler_mode_control[`TCC_ESB_HI:`TCC_ESB_LO])
			`TCC_ES_FALL: valid_b = fall_b;
			`TCC_ES_RISE: valid_b = rise_b;
			`TCC_ES_BOTH: valid_b = rise_b || fall_b;
			default:      valid_b = 1'b0;
		endcase
	end

	// Trigger B edge detection claims the output pin
	// Any edge select other than none counts as in use
	assign b_detect_used = prescaler_mode_control[`TCC_ESB_HI:`TCC_ESB_LO] != `TCC_ES_NONE; // RULE9

	// A loads from reverse A edge or from trigger B
	// Reverse phase picks the other edge of trigger A
	// Otherwise the valid edge of trigger B loads A
	assign cap_a_evt = a_is_cap && (rev_cap ? opposite_a : valid_b); // RULE7 RULE21 RULE13

	// B loads only from trigger A edges
	// Edge select none on A leaves B untouched
	assign cap_b_evt = b_is_cap && valid_a; // RULE8 RULE13 RULE14

	// Compare matches on count ticks
	// Tick qualified, so a count held by the divider matches once
	// Capture use blocks the compare of that register
	assign match_a_evt = tick && !a_is_cap && (up_counter_value == match_capture_a); // RULE4
	assign match_b_evt = tick && !b_is_cap && (up_counter_value == match_capture_b); // RULE5

	// Trigger A clears the count in mode 10
	// Needs no tick; acts on the detecting clock
	assign edge_clear = (run_mode == tcc_pkg::TCC_RUN_EDGE) && valid_a; // RULE18

	// Wrap past all-ones
	// Restart on a match at all-ones reloads zero and is no wrap
	assign wrap_evt = tick && (up_counter_value == `TCC_CNT_MAX)
		&& !(run_mode == tcc_pkg::TCC_RUN_RESTART && match_a_evt);

	// Prescaler: divide by 1, 2, 4 or 8
	// Tick when the selected low divider bits are all ones
	always_comb begin
		unique case (prescaler_mode_control[`TCC_DIV_HI:`TCC_DIV_LO])
			2'h0:    div_mask = 3'h0;
			2'h1:    div_mask = 3'h1;
			2'h2:    div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	end

	// Stop mode suppresses ticks entirely
	assign tick = (run_mode != tcc_pkg::TCC_RUN_STOP) && ((div_cnt & div_mask) == div_mask);

	// Prescale counter, held at zero while stopped
	// Starting from zero keeps the first tick aligned to the start
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt <= 3'h0;
		end else if (run_mode == tcc_pkg::TCC_RUN_STOP) begin
			div_cnt <= 3'h0;
		end else begin
			div_cnt <= div_cnt + 3'h1;
		end
	end

	// Main counter
	// Stop mode clears, so a new start counts from zero
	// Edge clear wins over a tick in the same clock
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			up_counter_value <= `TCC_CNT_ZERO;
		end else begin
			unique case (run_mode)
				tcc_pkg::TCC_RUN_STOP: begin
					up_counter_value <= `TCC_CNT_ZERO; // RULE22
				end
				tcc_pkg::TCC_RUN_EDGE: begin
					if (edge_clear) begin
						up_counter_value <= `TCC_CNT_ZERO; // RULE20
					end else if (tick) begin
						up_counter_value <= up_counter_value + 16'h0001; // RULE2
					end
				end
				tcc_pkg::TCC_RUN_RESTART: begin
					if (match_a_evt) begin
						up_counter_value <= `TCC_CNT_ZERO; // RULE16 RULE17
					end else if (tick) begin
						up_counter_value <= up_counter_value + 16'h0001;
					end
				end
				tcc_pkg::TCC_RUN_FREE: begin
					if (tick) begin
						up_counter_value <= up_counter_value + 16'h0001; // RULE1 RULE2 RULE6
					end
				end
			endcase
		end
	end

	// Mode control and wrap flag; set beats clear
	// Writing 1 to the wrap bit leaves it as it is
	// A wrap in the clearing clock keeps the flag set
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_mode_control <= `TCC_CTL_RST;
		end else begin
			if (bus_wr && avs_address == `TCC_OFS_MODE) begin
				timer_mode_control[7:1] <= avs_writedata[7:1];
				if (!avs_writedata[`TCC_WRAP_BIT]) begin
					timer_mode_control[`TCC_WRAP_BIT] <= 1'b0; // RULE3
				end
			end
			if (wrap_evt) begin
				timer_mode_control[`TCC_WRAP_BIT] <= 1'b1; // RULE2
			end
		end
	end

	// Capture, output and prescaler control
	// Unused upper bits are not stored and read as zero
	// Writes to other offsets leave these untouched
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_compare_control <= `TCC_CTL_RST;
			timer_output_control    <= `TCC_CTL_RST;
			prescaler_mode_control  <= `TCC_PRS_RST;
		end else if (bus_wr) begin
			if (avs_address == `TCC_OFS_CAPCTL) begin
				capture_compare_control <= {5'h00, avs_writedata[2:0]};
			end
			if (avs_address == `TCC_OFS_OUTCTL) begin
				// Level set and clear are strobes, not stored
				timer_output_control <= {3'h0, avs_writedata[4], 2'h0, avs_writedata[1:0]};
			end
			if (avs_address == `TCC_OFS_PRESCL) begin
				prescaler_mode_control <= avs_writedata[7:0];
			end
		end
	end

	// Register A: capture beats software write
	// A write that meets a capture is lost
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			match_capture_a <= `TCC_CNT_ZERO;
		end else if (cap_a_evt) begin
			match_capture_a <= up_counter_value; // RULE7
		end else if (bus_wr && avs_address == `TCC_OFS_MATCH_A) begin
			match_capture_a <= avs_writedata[15:0];
		end
	end

	// Register B: capture beats software write
	// A write that meets a capture is lost
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			match_capture_b <= `TCC_CNT_ZERO;
		end else if (cap_b_evt) begin
			match_capture_b <= up_counter_value; // RULE8 RULE11 RULE20
		end else if (bus_wr && avs_address == `TCC_OFS_MATCH_B) begin
			match_capture_b <= avs_writedata[15:0];
		end
	end

	// Event pulses, one cycle each
	// Matches and captures share one pulse per register
	// Trigger B edges still flag event A with reverse phase on
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			event_a_irq <= 1'b0;
			event_b_irq <= 1'b0;
		end else begin
			// Reverse-phase captures stay silent
			event_a_irq <= match_a_evt || (a_is_cap && valid_b); // RULE4 RULE10 RULE21
			event_b_irq <= match_b_evt || cap_b_evt; // RULE5 RULE10 RULE11
		end
	end

	// Output level generator
	// Software force wins over any toggle in the same clock
	// Force high beats force low when both are written
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_level <= 1'b0;
		end else if (bus_wr && avs_address == `TCC_OFS_OUTCTL
			&& (avs_writedata[`TCC_LVL_SET_BIT] || avs_writedata[`TCC_LVL_CLR_BIT])) begin
			// Software forces the start level
			out_level <= avs_writedata[`TCC_LVL_SET_BIT];
		end else if (run_mode == tcc_pkg::TCC_RUN_RESTART) begin
			// Square wave: high from restart through B match
			// Period is A plus one ticks, high time B plus one
			if (match_a_evt) begin
				out_level <= 1'b1; // RULE16 RULE17
			end else if (match_b_evt) begin
				out_level <= 1'b0; // RULE17
			end
		end else begin
			// Toggle on enabled matches and optional trigger A edge
			out_level <= out_level
				^ ((match_a_evt && timer_output_control[`TCC_INV_A_BIT]) // RULE10 RULE15
				^ (match_b_evt && timer_output_control[`TCC_INV_B_BIT]) // RULE15
				^ (valid_a && timer_mode_control[`TCC_EDGE_OUT_BIT])); // RULE12
		end
	end

	// Pin driver; idle low when disabled or pin claimed
	// Registered, so the pin sees no decode glitches
	// Internal level keeps running while the pin is held low
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			toggle_output <= 1'b0;
		end else begin
			toggle_output <= timer_output_control[`TCC_OE_BIT] && !b_detect_used && out_level; // RULE9
		end
	end

endmodule

// ### tcc_monitor.sv
// Checker of bus handshake, event pulses and output changes
`timescale 1ns/10ps
module tcc_monitor (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        toggle_output,
	input wire logic        event_a_irq,
	input wire logic        event_b_irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	// A fresh request waits exactly one cycle
	property p_wait_first;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first)
		else $error("request not answered after one wait cycle");
	// The answer stands for one cycle only
	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest low for more than one cycle");
	// No answer while the bus is idle
	property p_wait_idle;
		!(avs_read || avs_write) |=> avs_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle)
		else $error("waitrequest low without a request");
	// Read data only moves on a read answer
	property p_rdata;
		$changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read);
	endproperty
	a_rdata: assert property (p_rdata)
		else $error("read data changed outside a read answer");
	// Answer only follows a request
	property p_ack_cause;
		$fell(avs_waitrequest) |-> $past(avs_read || avs_write);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("answer without request");
	// Event pulses last one cycle
	property p_irq_a;
		event_a_irq |=> !event_a_irq;
	endproperty
	a_irq_a: assert property (p_irq_a)
		else $error("event a longer than one cycle");
	property p_irq_b;
		event_b_irq |=> !event_b_irq;
	endproperty
	a_irq_b: assert property (p_irq_b)
		else $error("event b longer than one cycle");
	// Output level moves only after an event or a register write
	property p_out_cause;
		$changed(toggle_output) |-> $past(event_a_irq) || $past(event_b_irq) || $past(avs_write) || $past(avs_write, 2);
	endproperty
	a_out_cause: assert property (p_out_cause)
		else $error("output changed without a cause");
endmodule

// ### tcc_pin_model.sv
// Far-side model: drives both trigger pins and measures the pulse output
`timescale 1ns/10ps
module tcc_pin_model (
	input  wire logic core_clk,
	input  wire logic toggle_output,
	output logic      trigger_in_a,
	output logic      trigger_in_b
);
	int   per_n = 0; // Last measured period in clocks
	int   hi_n  = 0; // Last measured high width in clocks
	int   pc    = 0; // Running period count
	int   hc    = 0; // Running high count
	logic prev  = 1'b0; // Output level one clock back
	initial begin
		trigger_in_a = 1'b0;
		trigger_in_b = 1'b0;
	end
	// Set one pin level just after an edge
	task automatic drv(input bit sel, input logic lvl);
		@(posedge core_clk);
		if (sel) begin
			trigger_in_b <= lvl;
		end else begin
			trigger_in_a <= lvl;
		end
	endtask
	// Rise to rise period and high width of the wave
	always @(posedge core_clk) begin
		prev <= toggle_output;
		if (toggle_output === 1'b1 && prev === 1'b0) begin
			per_n <= pc;
			hi_n <= hc;
			pc <= 1;
			hc <= 1;
		end else begin
			pc <= pc + 1;
			hc <= hc + int'(toggle_output === 1'b1);
		end
	end
endmodule

// ### tb_top.sv
// Self-checking bench of the capture/compare timer
`timescale 1ns/10ps
module tb_top;
	logic        core_clk, arst_n, avs_read, avs_write, t0;
	logic        avs_waitrequest, trigger_in_a, trigger_in_b, toggle_output, event_a_irq, event_b_irq;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rv, r2, lf;
	logic [15:0] a, nn;
	int          bad_count, checked, n, hi;
	logic [4:0]  ofs [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18, 5'h1C};
	logic [31:0] rst [8] = '{32'h0, 32'h0, 32'h0, 32'hA0, 32'h0, 32'h0, 32'h0, 32'h0};

	tcc_timer tcc_timer_i (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trigger_in_a(trigger_in_a),
		.trigger_in_b(trigger_in_b), .toggle_output(toggle_output), .event_a_irq(event_a_irq),
		.event_b_irq(event_b_irq));
	tcc_pin_model tcc_pin_model_i (.core_clk(core_clk), .toggle_output(toggle_output),
		.trigger_in_a(trigger_in_a), .trigger_in_b(trigger_in_b));

	// Next pseudo-random word
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Compare seen against expected
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Bounded wait for a level
	task automatic wt(ref logic s, input logic v, input int lim);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (s !== v && n < lim);
		if (s !== v) chk(0, 1);
	endtask
	// One Avalon access, held until waitrequest is low
	task automatic bus(input logic [4:0] ad, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= ad;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		wt(avs_waitrequest, 1'b0, 20);
		rv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] d);
		bus(ad, 1'b1, d);
	endtask
	task automatic rc(input logic [4:0] ad, input logic [31:0] e);
		bus(ad, 1'b0, 32'h0);
		chk(rv, e);
	endtask
	// Captured value lies a little behind the live count
	task automatic capchk(input logic [4:0] ad, input int lim);
		bus(ad, 1'b0, 32'h0);
		r2 = rv;
		bus(5'h10, 1'b0, 32'h0);
		chk(32'(rv > r2 && rv - r2 < lim), 32'h1);
	endtask
	task automatic complete_run();
		if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Watchdog against hangs
	initial begin
		repeat (80000) @(posedge core_clk);
		bad_count++;
		complete_run();
	end
	initial begin
		{arst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{bad_count, checked} = '0;
		lf = 32'h1C6C;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		foreach (ofs[i]) rc(ofs[i], rst[i]);
		wr(5'h10, 32'h1234);
		rc(5'h10, 32'h0);
		// Compare on both registers, invert codes 11 then 10
		for (int k = 0; k < 2; k++) begin
			lf = nx(lf);
			a = 16'h0040 + lf[5:0];
			wr(5'h00, 32'h0);
			wr(5'h14, a);
			rc(5'h14, a);
			wr(5'h18, a + 5);
			wr(5'h08, k ? 32'h11 : 32'h13);
			wr(5'h00, 32'h04);
			wt(event_a_irq, 1'b1, 400);
			t0 = toggle_output;
			repeat (2) @(posedge core_clk);
			chk(toggle_output, k ? t0 : !t0);
			wt(event_b_irq, 1'b1, 20);
			chk(n, 3);
			t0 = toggle_output;
			repeat (2) @(posedge core_clk);
			chk(toggle_output, !t0);
		end
		// Wrap and software clear of the flag
		wr(5'h18, 32'hFFFF);
		wt(event_b_irq, 1'b1, 70000);
		repeat (3) @(posedge core_clk);
		rc(5'h00, 32'h05);
		bus(5'h10, 1'b0, 32'h0);
		r2 = rv;
		bus(5'h10, 1'b0, 32'h0);
		chk(rv - r2, 32'h3);
		wr(5'h00, 32'h05);
		rc(5'h00, 32'h05);
		wr(5'h00, 32'h04);
		rc(5'h00, 32'h04);
		// Captures in free-running mode
		wr(5'h00, 32'h0);
		wr(5'h0C, 32'h90);
		wr(5'h04, 32'h04);
		wr(5'h08, 32'h09);
		wr(5'h00, 32'h04);
		repeat (30) @(posedge core_clk);
		tcc_pin_model_i.drv(0, 1'b1);
		wt(event_b_irq, 1'b1, 12);
		capchk(5'h18, 16);
		chk(toggle_output, 1'b1);
		wr(5'h0C, 32'h50);
		repeat (3) @(posedge core_clk);
		chk(toggle_output, 1'b0);
		wr(5'h04, 32'h05);
		tcc_pin_model_i.drv(1, 1'b1);
		wt(event_a_irq, 1'b1, 12);
		capchk(5'h14, 16);
		wr(5'h0C, 32'h60);
		bus(5'h18, 1'b0, 32'h0);
		r2 = rv;
		tcc_pin_model_i.drv(0, 1'b0);
		repeat (4) @(posedge core_clk);
		tcc_pin_model_i.drv(0, 1'b1);
		repeat (10) @(posedge core_clk);
		rc(5'h18, r2);
		wr(5'h0C, 32'h90);
		for (int k = 0; k < 2; k++) begin
			wr(5'h00, k ? 32'h06 : 32'h04);
			tcc_pin_model_i.drv(0, 1'b0);
			repeat (4) @(posedge core_clk);
			t0 = toggle_output;
			tcc_pin_model_i.drv(0, 1'b1);
			wt(event_b_irq, 1'b1, 12);
			repeat (3) @(posedge core_clk);
			chk(toggle_output, k ? !t0 : t0);
		end
		// Pulse generation: period and high width
		wr(5'h00, 32'h0);
		wr(5'h0C, 32'hA0);
		wr(5'h04, 32'h0);
		lf = nx(lf);
		a = 16'h0008 + lf[3:0];
		nn = {13'h0, lf[6:4]};
		wr(5'h14, a);
		wr(5'h18, nn);
		wr(5'h08, 32'h13);
		wr(5'h00, 32'h0C);
		repeat (3 * (a + 1) + 12) @(posedge core_clk);
		chk(tcc_pin_model_i.per_n, a + 1);
		chk(tcc_pin_model_i.hi_n, nn + 1);
		// Edge clear mode with reverse phase capture
		wr(5'h00, 32'h0);
		wr(5'h0C, 32'h90);
		wr(5'h04, 32'h07);
		wr(5'h08, 32'h01);
		wr(5'h00, 32'h08);
		repeat (60) @(posedge core_clk);
		tcc_pin_model_i.drv(0, 1'b0);
		hi = 0;
		for (int k = 0; k < 10; k++) begin
			@(posedge core_clk);
			hi += int'(event_a_irq === 1'b1);
		end
		chk(hi, 0);
		capchk(5'h14, 32);
		tcc_pin_model_i.drv(0, 1'b1);
		wt(event_b_irq, 1'b1, 12);
		bus(5'h10, 1'b0, 32'h0);
		chk(32'(rv < 16), 32'h1);
		bus(5'h18, 1'b0, 32'h0);
		chk(32'(rv > 60), 32'h1);
		complete_run();
	end
endmodule

bind tcc_timer tcc_monitor tcc_monitor_i (.core_clk(core_clk), .arst_n(arst_n), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.toggle_output(toggle_output), .event_a_irq(event_a_irq), .event_b_irq(event_b_irq));
